/* design/rda_pkg.sv */
// Purpose: Shared constants and carrier types of the rod drive interlock block.
// Assumes: 40 MHz scan clock, APB register access with 32-bit data.
// Notes:   Drive index 0,1 shim-safety rods, 2 regulating rod, 3 detector, 4 source.
package rda_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ       = 40_000_000;
   localparam int ACK_HOLD_S   = 2;
   localparam int ACK_HOLD_CYC = ACK_HOLD_S * CLK_HZ;
   localparam int HOLD_W       = 27;
   // -----------------------------------------------------------------
   // Drives and position scaling
   // -----------------------------------------------------------------
   localparam int NDRV         = 5;
   localparam int NROD         = 3;
   localparam int FINE_UM      = 100;    // One fine count is 0.1 mm.
   localparam int COARSE_UM    = 20_000; // One coarse count is 2 cm.
   localparam int COARSE_DIV   = COARSE_UM / FINE_UM;
   localparam logic [4:0] SHIM_MASK = 5'h07;
   localparam logic [4:0] ENG_MASK  = 5'h03;
   // -----------------------------------------------------------------
   // Register offsets and fields
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_SEL    = 8'h00;
   localparam logic [7:0] OFS_CMD    = 8'h04;
   localparam logic [7:0] OFS_TARGET = 8'h08;
   localparam logic [7:0] OFS_TEST   = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_POS0   = 8'h20;
   localparam int CMD_GANG   = 0;
   localparam int CMD_STEPUP = 1;
   localparam int CMD_STEPDN = 2;
   localparam int CMD_COARSE = 3;
   localparam int CMD_GO     = 4;
   localparam logic [2:0] SEL_NONE   = 3'h7;
   localparam logic [4:0] SCRAM_LAMPS = 5'h03;
   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic       rlRaise;
      logic       rlLower;
      logic       countOk;
      logic       srcMoving;
      logic [4:0] jam;
      logic [4:0] upLim;
      logic [4:0] loLim;
      logic [4:0] shimPt;
      logic [4:0] engaged;
      logic       shortPer;
      logic       highPwr;
      logic       setback;
      logic       trouble;
      logic       ack;
      logic       keyOn;
      logic       fluxTest;
      logic       evac;
   } rda_pins_s;
   typedef struct packed {
      logic [4:0] raise;
      logic [4:0] lower;
      logic [4:0] driveInd;
      logic [4:0] upInd;
      logic [4:0] loInd;
      logic [4:0] shimInd;
      logic [4:0] engInd;
      logic       jamInd;
      logic       wdIntlk;
      logic       srcMiss;
      logic       magnet;
      logic       scramRstInd;
      logic [4:0] lamps;
      logic       buzzer;
      logic       horn;
   } rda_outs_s;
endpackage

/* design/rda_rod_interlock.sv */
// Purpose: Rod drive permissives, selection, gang lower, scram reset and annunciator.
// Assumes: Console and plant contacts are asynchronous; positions are on this clock.
// Notes:   APB slave answers one cycle into the access phase.
//
// Overview of operation
// [RULE_01] Rod lowering only restricted by drive jam.
// [RULE_02] Raise needs at least two counts per second; code applies it to drives 0 to 3 only, not the source.
// [RULE_03] Low count shows interlock and source missing.
// [RULE_04] Moving source drive blocks all raising; code blocks drives 0 to 3 only, not the source.
// [RULE_05] Any drive jam lights console jam lamp.
// [RULE_06] Selecting a drive releases any other.
// [RULE_07] One drive selected, except gang lower.
// [RULE_08] Motion from switch, target, or steps.
// [RULE_09] Per-drive limit, shim, engage, drive indicators.
// [RULE_10] Source, detector, regulating rod omit some lamps.
// [RULE_11] Gang lower latches all rods lowering.
// [RULE_12] Any operator rod movement clears gang lower.
// [RULE_13] Setback also sets gang lower, no scram.
// [RULE_14] Short period or high power drops magnets.
// [RULE_15] Scram, setback, trouble sound alarm, light lamp.
// [RULE_16] Acknowledge silences buzzer, keeps cause lamps.
// [RULE_17] Magnets off until two-second acknowledge reset.
// [RULE_18] Acknowledge clears trouble lamp only if corrected.
// [RULE_19] Workstation test lights lamps and buzzer.
// [RULE_20] Evacuation button sounds evacuation horn.
// [RULE_21] All fine positions 0.1 mm, coarse 2 cm.
// [RULE_22] Magnets need test off, key on, reset.
// [RULE_23] Setback keeps inserting until cleared and reset.
// [RULE_24] Raise permissives rechecked and dropped every scan.
`timescale 1ns/10ps
module rda_rod_interlock
#(
   parameter int ACK_HOLD_CYC = rda_pkg::ACK_HOLD_CYC
)
(
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire rda_pkg::rda_pins_s   pinsIn,
   input  wire logic [4:0][15:0]     posFine,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   output rda_pkg::rda_outs_s        outs
);
   typedef struct packed {
      rda_pkg::rda_pins_s  sync1;
      rda_pkg::rda_pins_s  sync2;
      logic [4:0]          prevCause;
      logic [4:0]          unack;
      logic [4:0]          lamp;
      logic [4:0]          sel;
      logic                gang;
      logic                tgtAct;
      logic [15:0]         target;
      logic                test;
      logic                scramLat;
      logic                ackPrev;
      logic [rda_pkg::HOLD_W-1:0] holdCnt;
      logic                pready;
      logic [31:0]         prdata;
      logic                pslverr;
      rda_pkg::rda_outs_s  o;
   } rda_state_s;

   rda_state_s st_r;
   rda_state_s st_nxt;
   rda_pkg::rda_pins_s p;
   logic [4:0]  perm;
   logic [4:0]  cause;
   logic [4:0]  newCause;
   logic [4:0]  lampClr;
   logic [15:0] selPos;
   logic [15:0] stepAmt;
   logic        upReq;
   logic        dnReq;
   logic        ctlMove;
   logic        gangSet;
   logic        scramNow;
   logic        ackRise;
   logic        rstEvt;
   logic        apbAcc;
   logic        wrEn;
   logic [31:0] cmdW;
   logic [31:0] rdVal;
   logic        rdOk;
   logic [2:0]  selIdx;

   assign p = st_r.sync2;

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   // All contact logic below works on the second synchroniser stage only, so
   // each scan sees one consistent snapshot of the plant contacts.
   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.sync1  = pinsIn;
      st_nxt.sync2  = st_r.sync1;
      apbAcc        = psel && penable && st_r.pready;
      wrEn          = apbAcc && pwrite;
      cmdW          = (wrEn && paddr == rda_pkg::OFS_CMD) ? pwdata : 32'h0;
      // At most one select bit is set, so the loop yields that single drive.
      selIdx        = rda_pkg::SEL_NONE;
      selPos        = 16'h0;
      for (int i = 0; i < rda_pkg::NDRV; i++)
      begin
         if (st_r.sel[i])
         begin
            selIdx = 3'(i);
            selPos = posFine[i];
         end
      end

      // Drive selection: a write picks one drive (none for an index above 4) and drops the rest.
      if (wrEn && paddr == rda_pkg::OFS_SEL)
      begin
         st_nxt.sel    = (pwdata[2:0] < 3'(rda_pkg::NDRV)) ? 5'(5'h01 << pwdata[2:0]) : 5'h00; // RULE_06 RULE_07
         st_nxt.tgtAct = 1'b0;
      end
      if (wrEn && paddr == rda_pkg::OFS_TARGET)
      begin
         st_nxt.target = pwdata[15:0];
      end
      if (wrEn && paddr == rda_pkg::OFS_TEST)
      begin
         st_nxt.test = pwdata[0];
      end

      // Steps are turned into a target so one mechanism ends all step and target motion.
      stepAmt = cmdW[rda_pkg::CMD_COARSE] ? 16'(rda_pkg::COARSE_DIV) : 16'h1;
      if (cmdW[rda_pkg::CMD_STEPUP])
      begin
         st_nxt.target = selPos + stepAmt; // RULE_08
         st_nxt.tgtAct = 1'b1;
      end
      else if (cmdW[rda_pkg::CMD_STEPDN])
      begin
         st_nxt.target = (selPos > stepAmt) ? selPos - stepAmt : 16'h0; // RULE_08
         st_nxt.tgtAct = 1'b1;
      end
      else if (cmdW[rda_pkg::CMD_GO])
      begin
         st_nxt.tgtAct = 1'b1; // RULE_08
      end
      upReq = p.rlRaise || (st_r.tgtAct && selPos < st_r.target);
      dnReq = p.rlLower || (st_r.tgtAct && selPos > st_r.target);
      if (p.rlRaise || p.rlLower || (st_r.tgtAct && selPos == st_r.target))
      begin
         st_nxt.tgtAct = 1'b0;
      end

      // Gang lower: setting wins over the clearing movement.
      ctlMove = (selIdx < 3'(rda_pkg::NROD))
                && (p.rlRaise || p.rlLower || (|cmdW[rda_pkg::CMD_GO:rda_pkg::CMD_STEPUP]));
      gangSet = cmdW[rda_pkg::CMD_GANG] || p.setback; // RULE_11 RULE_13 RULE_23
      st_nxt.gang = gangSet || (st_r.gang && !ctlMove); // RULE_12

      // Raise permissives, re-evaluated on every scan.
      // The source is gated by jam and upper limit only: its own motion is what blocks drives 0 to 3.
      for (int i = 0; i < rda_pkg::NDRV; i++)
      begin
         perm[i] = !p.jam[i] && !p.upLim[i];
         if (i < rda_pkg::NDRV - 1)
         begin
            perm[i] = perm[i] && p.countOk && !p.srcMoving; // RULE_02 RULE_04 RULE_24
         end
         st_nxt.o.raise[i] = st_r.sel[i] && !st_r.gang && upReq && !dnReq && perm[i];
         st_nxt.o.lower[i] = ((st_r.sel[i] && !st_r.gang && dnReq && !upReq)
                              || (st_r.gang && i < rda_pkg::NROD)) && !p.jam[i]; // RULE_01 RULE_11
      end

      // Indicators, masked where a drive has no such lamp.
      st_nxt.o.driveInd = st_r.sel; // RULE_09
      st_nxt.o.upInd    = p.upLim;
      st_nxt.o.loInd    = p.loLim;
      st_nxt.o.shimInd  = p.shimPt & rda_pkg::SHIM_MASK;  // RULE_10
      st_nxt.o.engInd   = p.engaged & rda_pkg::ENG_MASK;  // RULE_10
      st_nxt.o.jamInd   = |p.jam;   // RULE_05
      st_nxt.o.wdIntlk  = !p.countOk; // RULE_03
      st_nxt.o.srcMiss  = !p.countOk; // RULE_03
      st_nxt.o.horn     = p.evac;   // RULE_20

      // Scram latch and the two-second acknowledge hold.
      scramNow = p.shortPer || p.highPwr;
      ackRise  = p.ack && !st_r.ackPrev;
      // The count saturates, so one long press gives one reset only;
      // releasing the button restarts the two-second hold from zero.
      st_nxt.ackPrev = p.ack;
      st_nxt.holdCnt = p.ack ? ((st_r.holdCnt == rda_pkg::HOLD_W'(ACK_HOLD_CYC))
                                ? st_r.holdCnt : st_r.holdCnt + 1'b1)
                             : '0;
      rstEvt = p.ack && !scramNow
               && st_r.holdCnt == rda_pkg::HOLD_W'(ACK_HOLD_CYC - 1); // RULE_17
      st_nxt.scramLat = scramNow || (st_r.scramLat && !rstEvt);
      st_nxt.o.scramRstInd = rstEvt || (st_r.o.scramRstInd && !scramNow);
      st_nxt.o.magnet = !scramNow && !(st_r.scramLat && !rstEvt)
                        && p.keyOn && !p.fluxTest; // RULE_14 RULE_22

      // Annunciator: new causes sound the buzzer, lamps stay while causes stand.
      // Scram lamps wait for the scram reset, the others for an acknowledge.
      cause    = {|p.jam, p.trouble, p.setback, p.highPwr, p.shortPer};
      newCause = cause & ~st_r.prevCause;
      st_nxt.prevCause = cause;
      st_nxt.unack = (st_r.unack & ~{5{ackRise}}) | newCause; // RULE_15 RULE_16
      lampClr = ({5{ackRise}} & ~rda_pkg::SCRAM_LAMPS & ~cause)
                | ({5{rstEvt}} & rda_pkg::SCRAM_LAMPS & ~cause); // RULE_18
      st_nxt.lamp = (st_r.lamp & ~lampClr) | cause; // RULE_15
      st_nxt.o.lamps  = st_nxt.lamp | {5{st_nxt.test}}; // RULE_19
      st_nxt.o.buzzer = (|st_nxt.unack) || st_nxt.test; // RULE_19

      // APB read mux; positions carry coarse above fine.
      rdOk  = 1'b1;
      rdVal = 32'h0;
      case (paddr)
         rda_pkg::OFS_SEL:    rdVal = {29'h0, selIdx};
         rda_pkg::OFS_CMD:    rdVal = 32'h0;
         rda_pkg::OFS_TARGET: rdVal = {16'h0, st_r.target};
         rda_pkg::OFS_TEST:   rdVal = {31'h0, st_r.test};
         rda_pkg::OFS_STATUS: rdVal = {14'h0, st_r.lamp, st_r.o.scramRstInd, st_r.scramLat,
                                       st_r.o.magnet, st_r.o.buzzer, st_r.tgtAct, st_r.gang,
                                       st_r.o.jamInd, !p.countOk, st_r.sel};
         default:
         begin
            rdOk = 1'b0;
            for (int i = 0; i < rda_pkg::NDRV; i++)
            begin
               if (paddr == rda_pkg::OFS_POS0 + 8'(4 * i))
               begin
                  rdOk  = 1'b1;
                  rdVal = {16'(posFine[i] / 16'(rda_pkg::COARSE_DIV)), posFine[i]}; // RULE_21
               end
            end
         end
      endcase
      // One wait state: pready rises the cycle after the access phase starts.
      st_nxt.pready  = psel && penable && !st_r.pready;
      st_nxt.prdata  = (psel && penable && !st_r.pready && !pwrite) ? rdVal : 32'h0;
      st_nxt.pslverr = psel && penable && !st_r.pready && !rdOk;
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   // The scram latch resets set, so magnets need a reset hold after power-up.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_r          <= '0;
         st_r.scramLat <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Every port comes straight from the state register.
   assign pready  = st_r.pready;
   assign prdata  = st_r.prdata;
   assign pslverr = st_r.pslverr;
   assign outs    = st_r.o;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   // Outputs are registered, so each check on the pins looks one scan back at them.
   raise_perm_a: assert property (@(posedge clk) disable iff (srst) // RULE_02
      (|st_r.o.raise[3:0]) |-> $past(p.countOk && !p.srcMoving))
      else $error("Raise without count or with source moving.");

   lower_free_a: assert property (@(posedge clk) disable iff (srst) // RULE_01
      st_r.gang && !p.jam[0] |=> st_r.o.lower[0])
      else $error("Gang lower did not lower rod.");

   jam_lower_a: assert property (@(posedge clk) disable iff (srst) // RULE_01
      (st_r.o.lower & $past(p.jam)) == 5'h00)
      else $error("Jammed drive driven down.");

   wd_intlk_a: assert property (@(posedge clk) disable iff (srst) // RULE_03
      !p.countOk |=> st_r.o.wdIntlk && st_r.o.srcMiss)
      else $error("Low count rate not indicated.");

   src_block_a: assert property (@(posedge clk) disable iff (srst) // RULE_04
      p.srcMoving |=> st_r.o.raise[3:0] == 4'h0)
      else $error("Raise while source drive moving.");

   jam_lamp_a: assert property (@(posedge clk) disable iff (srst) // RULE_05
      (|p.jam) |=> st_r.o.jamInd)
      else $error("Jam lamp dark during jam.");

   sel_drive_a: assert property (@(posedge clk) disable iff (srst) // RULE_06 RULE_09
      st_r.o.driveInd == $past(st_r.sel))
      else $error("Drive lamp does not follow selection.");

   one_sel_a: assert property (@(posedge clk) disable iff (srst) // RULE_07
      $onehot0(st_r.sel) && $onehot0(st_r.o.raise))
      else $error("More than one drive selected.");

   raise_sel_a: assert property (@(posedge clk) disable iff (srst) // RULE_07 RULE_08
      (st_r.o.raise & ~$past(st_r.sel)) == 5'h00)
      else $error("Raise on a drive not selected.");

   ind_mask_a: assert property (@(posedge clk) disable iff (srst) // RULE_10
      st_r.o.shimInd[4:3] == 2'b00 && st_r.o.engInd[4:2] == 3'b000)
      else $error("Lamp lit on a drive without it.");

   gang_low_a: assert property (@(posedge clk) disable iff (srst) // RULE_11
      st_r.gang |=> (st_r.o.lower[2:0] | $past(p.jam[2:0])) == 3'h7)
      else $error("Gang lower missed a rod.");

   gang_clr_a: assert property (@(posedge clk) disable iff (srst) // RULE_12
      ctlMove && !gangSet |=> !st_r.gang)
      else $error("Gang lower not cleared by movement.");

   gang_set_a: assert property (@(posedge clk) disable iff (srst) // RULE_13 RULE_23
      p.setback |=> st_r.gang)
      else $error("Setback did not set gang lower.");

   scram_mag_a: assert property (@(posedge clk) disable iff (srst) // RULE_14
      p.shortPer || p.highPwr |=> (!st_r.o.magnet) [*2])
      else $error("Magnet held through fast scram.");

   scram_lamp_a: assert property (@(posedge clk) disable iff (srst) // RULE_15
      p.shortPer |=> st_r.o.lamps[0])
      else $error("Short period lamp dark.");

   buzz_new_a: assert property (@(posedge clk) disable iff (srst) // RULE_15
      (|newCause) |=> st_r.o.buzzer)
      else $error("New alarm cause did not sound buzzer.");

   ack_buzz_a: assert property (@(posedge clk) disable iff (srst) // RULE_16
      ackRise && newCause == 5'h00 && !st_nxt.test |=> !st_r.o.buzzer)
      else $error("Acknowledge did not silence buzzer.");

   mag_hold_a: assert property (@(posedge clk) disable iff (srst) // RULE_17
      st_r.o.magnet |-> $past(!st_r.scramLat || rstEvt))
      else $error("Magnet energised while scram latched.");

   rst_ind_a: assert property (@(posedge clk) disable iff (srst) // RULE_17
      rstEvt |=> st_r.o.scramRstInd && !st_r.scramLat)
      else $error("Scram reset not shown or latch kept.");

   lamp_keep_a: assert property (@(posedge clk) disable iff (srst) // RULE_18
      p.trouble |=> st_r.o.lamps[3])
      else $error("Trouble lamp dark while trouble stands.");

   lamp_clr_a: assert property (@(posedge clk) disable iff (srst) // RULE_18
      ackRise && !p.trouble && !st_nxt.test |=> !st_r.o.lamps[3])
      else $error("Corrected trouble lamp kept lit.");

   ann_test_a: assert property (@(posedge clk) disable iff (srst) // RULE_19
      st_r.test |-> (&st_r.o.lamps) && st_r.o.buzzer)
      else $error("Annunciator test incomplete.");

   horn_a: assert property (@(posedge clk) disable iff (srst) // RULE_20
      p.evac |=> st_r.o.horn)
      else $error("Evacuation horn silent.");

   mag_perm_a: assert property (@(posedge clk) disable iff (srst) // RULE_22
      st_r.o.magnet |-> $past(p.keyOn && !p.fluxTest))
      else $error("Magnet on in test or with key off.");

   raise_lim_a: assert property (@(posedge clk) disable iff (srst) // RULE_24
      (st_r.o.raise & $past(p.jam | p.upLim)) == 5'h00)
      else $error("Raise kept after a permissive failed.");

   // Main scenarios that the bench is expected to reach.
   gang_c:  cover property (@(posedge clk) disable iff (srst) $rose(st_r.gang));
   reset_c: cover property (@(posedge clk) disable iff (srst) rstEvt);
   raise_c: cover property (@(posedge clk) disable iff (srst) |st_r.o.raise);
   scram_c: cover property (@(posedge clk) disable iff (srst) $fell(st_r.o.magnet));
   test_c:  cover property (@(posedge clk) disable iff (srst) st_r.test && st_r.o.buzzer);
endmodule

/* dv/rda_drive_model.sv */
// Purpose: Behavioural rod drive mechanics that answer the drive relays.
// Assumes: One fine count of travel per clock while a relay is on.
// Notes:   Travel stops at zero; limit contacts are driven by the bench.
`timescale 1ns/10ps
module rda_drive_model
(
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire rda_pkg::rda_outs_s outs,
   output logic [4:0][15:0]        posFine
);
   // --------------------------------------------------------------
   // Drive travel
   // --------------------------------------------------------------
   // Raise wins over lower, so a relay fault shows as upward drift.
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 5; i++)
      begin
         if (srst)
            posFine[i] <= 16'h0190;
         else if (outs.raise[i])
            posFine[i] <= posFine[i] + 16'h0001;
         else if (outs.lower[i] && posFine[i] != 16'h0000)
            posFine[i] <= posFine[i] - 16'h0001;
      end
   end
endmodule

/* dv/tb.sv */
// Purpose: Self-checking bench of the rod drive interlock block.
// Assumes: Pins reach outputs three edges after they change, four via gang lower.
// Notes:   The acknowledge hold is shortened to HOLD cycles.
`timescale 1ns/10ps
module tb;
   localparam int HOLD = 20;
   logic               clk;
   logic               srst;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [7:0]         paddr;
   logic [31:0]        pwdata;
   logic               pready;
   logic [31:0]        prdata;
   logic               pslverr;
   logic [4:0][15:0]   posFine;
   rda_pkg::rda_pins_s pins;
   rda_pkg::rda_outs_s outs;
   logic [31:0]        rd;
   logic               er;
   int                 num_errors;
   int                 n_compared;

   rda_rod_interlock #(.ACK_HOLD_CYC(HOLD)) i_rda_rod_interlock
   (
      .clk(clk), .srst(srst), .pinsIn(pins), .posFine(posFine),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .outs(outs)
   );
   rda_drive_model i_rda_drive_model
   (
      .clk(clk), .srst(srst), .outs(outs), .posFine(posFine)
   );

   // --------------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One APB transfer; waits for pready, then idles one cycle.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      rd = prdata;
      er = pslverr;
      if (k >= 50) num_errors++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic stop_test;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   // Reset state, positions and an unmapped access.
   task automatic t_reset;
      chk(outs.magnet, 0);
      apb(0, rda_pkg::OFS_STATUS, 0);
      chk(rd[11], 1);
      apb(0, rda_pkg::OFS_POS0 + 8'h0c, 0);
      chk(rd, 32'h0002_0190);
      apb(0, 8'h40, 0);
      chk(er, 1);
      $display("t_reset done");
   endtask

   // Reselection releases the previous drive.
   task automatic t_select;
      apb(1, rda_pkg::OFS_SEL, 2);
      apb(1, rda_pkg::OFS_SEL, 5);
      apb(0, rda_pkg::OFS_SEL, 0);
      chk(rd[2:0], rda_pkg::SEL_NONE);
      apb(1, rda_pkg::OFS_SEL, 2);
      apb(1, rda_pkg::OFS_SEL, 0);
      cyc(3);
      chk(outs.driveInd, 5'h01);
      apb(0, rda_pkg::OFS_STATUS, 0);
      chk(rd[4:0], 5'h01);
      $display("t_select done");
   endtask

   // Raise permissives, jam and lowering of drive 0.
   task automatic t_raise;
      pins.countOk <= 1'b1;
      pins.rlRaise <= 1'b1;
      cyc(4);
      chk(outs.raise, 5'h01);
      pins.countOk <= 1'b0;
      cyc(4);
      chk(outs.raise, 0);
      chk({outs.wdIntlk, outs.srcMiss}, 2'b11);
      pins.countOk <= 1'b1;
      pins.srcMoving <= 1'b1;
      cyc(4);
      chk(outs.raise, 0);
      pins.srcMoving <= 1'b0;
      pins.rlRaise <= 1'b0;
      pins.rlLower <= 1'b1;
      pins.jam <= 5'h01;
      cyc(4);
      chk(outs.jamInd, 1);
      chk(outs.lower, 0);
      pins.jam <= 5'h00;
      cyc(4);
      chk(outs.lower, 5'h01);
      pins.rlLower <= 1'b0;
      cyc(4);
      $display("t_raise done");
   endtask

   // Motion to an entered target height.
   task automatic t_target;
      apb(0, rda_pkg::OFS_POS0, 0);
      apb(1, rda_pkg::OFS_TARGET, {16'h0000, rd[15:0] + 16'h0020});
      apb(1, rda_pkg::OFS_CMD, 32'h1 << rda_pkg::CMD_GO);
      cyc(2);
      chk(outs.raise, 5'h01);
      cyc(60);
      chk(outs.raise, 0);
      $display("t_target done");
   endtask

   // Gang lower set by command and setback, cleared by movement.
   task automatic t_gang;
      apb(1, rda_pkg::OFS_CMD, 32'h1 << rda_pkg::CMD_GANG);
      cyc(3);
      chk(outs.lower, 5'h07);
      pins.rlLower <= 1'b1;
      cyc(4);
      pins.rlLower <= 1'b0;
      cyc(4);
      chk(outs.lower, 0);
      pins.setback <= 1'b1;
      cyc(5);
      chk(outs.lower, 5'h07);
      chk({outs.lamps[2], outs.buzzer, outs.magnet}, 3'b110);
      pins.setback <= 1'b0;
      pins.ack <= 1'b1;
      cyc(4);
      pins.ack <= 1'b0;
      cyc(4);
      chk(outs.lamps[2], 0);
      chk(outs.lower, 5'h07);
      $display("t_gang done");
   endtask

   // Fast scram, acknowledge and the held reset.
   task automatic t_scram;
      pins.shortPer <= 1'b1;
      pins.ack <= 1'b1;
      cyc(4);
      pins.ack <= 1'b0;
      pins.highPwr <= 1'b1;
      cyc(4);
      chk({outs.lamps[1:0], outs.buzzer}, 3'b111);
      pins.ack <= 1'b1;
      cyc(4);
      chk({outs.lamps[1:0], outs.buzzer}, 3'b110);
      pins.shortPer <= 1'b0;
      pins.highPwr <= 1'b0;
      pins.fluxTest <= 1'b1;
      cyc(HOLD + 8);
      chk({outs.scramRstInd, outs.magnet}, 2'b10);
      pins.fluxTest <= 1'b0;
      cyc(4);
      chk(outs.magnet, 1);
      chk(outs.lamps[1:0], 0);
      pins.ack <= 1'b0;
      pins.highPwr <= 1'b1;
      cyc(4);
      chk(outs.magnet, 0);
      pins.highPwr <= 1'b0;
      pins.ack <= 1'b1;
      cyc(HOLD / 2);
      pins.ack <= 1'b0;
      cyc(HOLD);
      chk(outs.magnet, 0);
      $display("t_scram done");
   endtask

   // Trouble lamp, lamp test, horn and limit, shim and engage indicators.
   task automatic t_annun;
      pins.trouble <= 1'b1;
      cyc(4);
      pins.ack <= 1'b1;
      cyc(4);
      pins.ack <= 1'b0;
      chk(outs.lamps[3], 1);
      apb(1, rda_pkg::OFS_TEST, 1);
      cyc(3);
      chk({outs.lamps, outs.buzzer}, 6'h3f);
      apb(1, rda_pkg::OFS_TEST, 0);
      pins.evac <= 1'b1;
      pins.upLim <= 5'h1f;
      pins.loLim <= 5'h15;
      pins.shimPt <= 5'h1f;
      pins.engaged <= 5'h1f;
      cyc(4);
      chk(outs.horn, 1);
      chk({outs.upInd, outs.loInd}, 10'h3f5);
      chk({outs.shimInd, outs.engInd}, 10'h0e3);
      $display("t_annun done");
   endtask

   // --------------------------------------------------------------
   // Clock, watchdog and main sequence
   // --------------------------------------------------------------
   // The clock runs at 40 MHz.
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // The tests need well under a thousand cycles.
   initial
   begin
      #(25 * 5000);
      num_errors++;
      stop_test();
   end

   // Reset, then each scenario in turn.
   initial
   begin
      num_errors = 0;
      n_compared = 0;
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pins = '0;
      pins.keyOn = 1'b1;
      cyc(10);
      srst <= 1'b0;
      cyc(5);
      t_reset();
      t_select();
      t_raise();
      t_target();
      t_gang();
      t_scram();
      t_annun();
      stop_test();
   end
endmodule
